// ### logic/irl_top.sv
// Interrupt request logic: source flags, masking, entry sequencing and wake-up.
// Operation
// - Four request sources: edge pin, timer overflow, upper port nibble change, comparator.
// - Global enable at control bit 7 gates all requests; reset clears it.
// - Return-from-interrupt sets the global enable again.
// - Taking an interrupt clears global enable, pushes return address, vectors to 0004h.
// - Source flags set on events regardless of individual or global enables.
// - After global enable is cleared, next cycle forces a no-op; requests stay pending.
// - Pin and port-change latency to vector is three or four instruction cycles; here the vector loads 6 to 9 clocks after the event.
// - Edge pin uses option bit 6 for polarity and sets control bit 1.
// - Clearing control bit 4 disables the edge pin interrupt.
// - Enabled edge pin request wakes from sleep; global enable decides vectoring.
// - Timer rolling from FFh to 00h sets control bit 2; enable at bit 5.
// - Change on port bits 7 to 4 sets control bit 0, gated by own enable.
// - A change coinciding with a port read at Q2 may be lost.
// - Comparator flag lives in the peripheral flag register, enable in peripheral enable register.
// - Requests are sampled at Q1; the pin flag is set during Q4 or Q1.
// - Only the return address is pushed on entry; nothing else is saved.
// - Comparator wake sets peripheral flag bit 6; other wakes leave it.
`include "irl_defs.svh"

module irl_top
    import irl_pkg::*;
(
    input  wire logic        MCLK,             // System clock, 25 MHz.
    input  wire logic        SYS_RST,          // Synchronous reset, active high.
    input  wire logic        CE,               // Clock enable; low freezes all state.
    input  wire logic [7:0]  ADDR,             // Register address.
    input  wire logic [7:0]  WDATA,            // Register write data.
    input  wire logic        WR,               // Write strobe.
    input  wire logic        RD,               // Read strobe.
    output logic      [7:0]  RDATA,            // Read data, valid the cycle after RD.
    input  wire logic        EXT_IRQ_PIN,      // External interrupt pin.
    input  wire logic [7:0]  TIMER_COUNT,      // Timer count value.
    input  wire logic [3:0]  GPIO_BANK_TWO_HI, // Upper nibble of the port pins.
    input  wire logic        PORT_READ,        // Core reads the port this cycle.
    input  wire logic        CMP_OUT,          // Comparator output level.
    input  wire logic        RETURN_FROM_IRQ,  // Core executes the return-from-interrupt instruction.
    input  wire logic        SLEEP_ENTER,      // Core executes the sleep instruction.
    input  wire logic [12:0] RETURN_PC,        // Address to resume at after service.
    output logic             CORE_REQ,         // A source has flag and enable set.
    output logic             IRQ_ENTRY,        // Pulse: push STACK_DATA and insert the entry cycle.
    output logic      [12:0] STACK_DATA,       // Return address to push.
    output logic             VECTOR_LOAD,      // Pulse: load VECTOR_ADDR into the program counter.
    output logic      [12:0] VECTOR_ADDR,      // Interrupt vector.
    output logic             FORCE_NOP,        // Core executes a no-op this instruction cycle.
    output logic             SLEEPING,         // Core is asleep.
    output logic             WAKE,             // Pulse: leave sleep.
    output logic             Q1_PHASE,         // High in phase Q1.
    output logic             IRQ               // Level interrupt from the event status bits.
);
    irl_phase_t phase;
    irl_state_t state;
    irl_state_t next_state;

    logic [7:0]  ctrl;
    logic [7:0]  pflag;
    logic [7:0]  pen;
    logic [7:0]  option;
    logic [7:0]  evt_stat;
    logic [7:0]  evt_mask;
    logic [7:0]  next_ctrl;
    logic [7:0]  next_pflag;
    logic [7:0]  next_pen;
    logic [7:0]  next_option;
    logic [7:0]  next_evt_stat;
    logic [7:0]  next_evt_mask;
    logic [7:0]  next_rdata;

    logic [7:0]  timer_prev;
    logic [3:0]  port_latch;
    logic        port_primed;
    logic        ext_pending;
    logic        gie_hold;
    logic        nop_cycle;
    logic        sleeping;
    logic        entry_pulse;
    logic        vector_pulse;
    logic [12:0] stack_data;
    logic [12:0] vector_addr;
    logic [7:0]  next_timer_prev;
    logic [3:0]  next_port_latch;
    logic        next_port_primed;
    logic        next_ext_pending;
    logic        next_gie_hold;
    logic        next_nop_cycle;
    logic        next_sleeping;
    logic        next_entry_pulse;
    logic        next_vector_pulse;
    logic        next_wake;
    logic [12:0] next_stack_data;
    logic [12:0] next_vector_addr;

    logic        ext_rise;
    logic        ext_fall;
    logic        cmp_rise;
    logic        cmp_fall;
    logic        ext_edge;
    logic        tov_event;
    logic        pch_event;
    logic        cmp_event;
    logic        pending;
    logic        take;
    logic        wr_ctrl;
    logic        gie_cleared;
    logic        is_q1;
    logic        wake_now;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        hit = (addr == offset);
    endfunction

    irl_phase_gen u_phase (
        .clk   (MCLK),
        .rst   (SYS_RST),
        .ce    (CE),
        .phase (phase)
    );

    irl_edge_det #(.W(1)) u_ext_edge (
        .clk  (MCLK),
        .rst  (SYS_RST),
        .ce   (CE),
        .din  (EXT_IRQ_PIN),
        .rise (ext_rise),
        .fall (ext_fall)
    );

    irl_edge_det #(.W(1)) u_cmp_edge (
        .clk  (MCLK),
        .rst  (SYS_RST),
        .ce   (CE),
        .din  (CMP_OUT),
        .rise (cmp_rise),
        .fall (cmp_fall)
    );

    // Source events, detected every clock whatever the enables say.
    always_comb
    begin
        is_q1     = (phase == IRL_Q1);
        ext_edge  = option[`IRL_OPT_EDGE_SEL] ? ext_rise : ext_fall;
        tov_event = (timer_prev == `IRL_TIMER_MAX) && (TIMER_COUNT == `IRL_TIMER_ZERO);
        // The mismatch is judged against the value the last port read latched, so a change that
        // lands in the same Q2 as a read is absorbed into the latch and never raises the flag.
        pch_event = port_primed && (GPIO_BANK_TWO_HI != port_latch)
                    && !(PORT_READ && (phase == IRL_Q2));
        cmp_event = cmp_rise | cmp_fall;
    end

    // Request and take decision.
    always_comb
    begin
        pending = (ctrl[`IRL_CTRL_EXT_FLAG] & ctrl[`IRL_CTRL_EXT_EN])
                | (ctrl[`IRL_CTRL_TOV_FLAG] & ctrl[`IRL_CTRL_TOV_EN])
                | (ctrl[`IRL_CTRL_PCH_FLAG] & ctrl[`IRL_CTRL_PCH_EN])
                | (ctrl[`IRL_CTRL_PEIE] & (|(pflag & pen)));
        // Sampled only at Q1; an entry runs one forced cycle then vectors, 6 to 9 clocks after the event.
        take    = is_q1 && (state == IRL_ST_RUN) && pending && ctrl[`IRL_CTRL_GIE]
                  && !gie_hold && !nop_cycle && !sleeping;
        wake_now = sleeping && pending;
        wr_ctrl  = WR && hit(ADDR, `IRL_REG_CTRL);
        gie_cleared = wr_ctrl && !WDATA[`IRL_CTRL_GIE] && ctrl[`IRL_CTRL_GIE];
    end

    // Register file: software writes first, then hardware sets and clears, so a hardware update beats a software write.
    always_comb
    begin
        next_ctrl     = ctrl;
        next_pflag    = pflag;
        next_pen      = pen;
        next_option   = option;
        next_evt_mask = evt_mask;
        next_evt_stat = evt_stat;
        next_rdata    = `IRL_ZERO8;
        if (wr_ctrl)
            next_ctrl = WDATA;
        if (WR && hit(ADDR, `IRL_REG_PFLAG))
            next_pflag = WDATA & `IRL_PER_MASK;
        if (WR && hit(ADDR, `IRL_REG_PEN))
            next_pen = WDATA & `IRL_PER_MASK;
        if (WR && hit(ADDR, `IRL_REG_OPTION))
            next_option = WDATA;
        if (WR && hit(ADDR, `IRL_REG_EVT_MASK))
            next_evt_mask = WDATA & `IRL_EVT_MASK_ALL;
        if (WR && hit(ADDR, `IRL_REG_EVT_STAT))
            next_evt_stat = evt_stat & ~WDATA;
        if (RETURN_FROM_IRQ)
            next_ctrl[`IRL_CTRL_GIE] = 1'b1;
        if (take)
            next_ctrl[`IRL_CTRL_GIE] = 1'b0;
        // The pin flag only lands in Q4 or Q1; an edge seen in Q2 or Q3 waits in ext_pending.
        if ((ext_pending || ext_edge) && (phase == IRL_Q4 || is_q1))
            next_ctrl[`IRL_CTRL_EXT_FLAG] = 1'b1;
        if (tov_event)
            next_ctrl[`IRL_CTRL_TOV_FLAG] = 1'b1;
        if (pch_event)
            next_ctrl[`IRL_CTRL_PCH_FLAG] = 1'b1;
        // A comparator change sets bit 6 awake or asleep; other wakes never touch it.
        if (cmp_event)
            next_pflag[`IRL_PER_CMP_BIT] = 1'b1;
        if (take)
            next_evt_stat[`IRL_EVT_TAKEN] = 1'b1;
        if (wake_now)
            next_evt_stat[`IRL_EVT_WAKE] = 1'b1;
        if (gie_hold && is_q1)
            next_evt_stat[`IRL_EVT_NOP] = 1'b1;
        if (RD)
        begin
            if (hit(ADDR, `IRL_REG_CTRL))
                next_rdata = ctrl;
            else if (hit(ADDR, `IRL_REG_PFLAG))
                next_rdata = pflag;
            else if (hit(ADDR, `IRL_REG_PEN))
                next_rdata = pen;
            else if (hit(ADDR, `IRL_REG_OPTION))
                next_rdata = option;
            else if (hit(ADDR, `IRL_REG_EVT_STAT))
                next_rdata = evt_stat;
            else if (hit(ADDR, `IRL_REG_EVT_MASK))
                next_rdata = evt_mask;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            ctrl     <= `IRL_CTRL_RST;
            pflag    <= `IRL_ZERO8;
            pen      <= `IRL_ZERO8;
            option   <= `IRL_OPTION_RST;
            evt_stat <= `IRL_ZERO8;
            evt_mask <= `IRL_ZERO8;
            RDATA    <= `IRL_ZERO8;
        end
        else if (CE)
        begin
            ctrl     <= next_ctrl;
            pflag    <= next_pflag;
            pen      <= next_pen;
            option   <= next_option;
            evt_stat <= next_evt_stat;
            evt_mask <= next_evt_mask;
            RDATA    <= next_rdata;
        end
    end

    // Source tracking, entry sequence, no-op slot and sleep.
    always_comb
    begin
        next_timer_prev   = TIMER_COUNT;
        next_port_primed  = 1'b1;
        next_port_latch   = port_latch;
        if (!port_primed || (PORT_READ && phase == IRL_Q2))
            next_port_latch = GPIO_BANK_TWO_HI;
        next_ext_pending  = ext_pending;
        if (phase == IRL_Q4 || is_q1)
            next_ext_pending = 1'b0;
        else if (ext_edge)
            next_ext_pending = 1'b1;
        // Clearing the enable opens a one-cycle no-op slot; flags are untouched so requests wait.
        next_gie_hold  = gie_hold;
        next_nop_cycle = nop_cycle;
        if (is_q1)
        begin
            next_nop_cycle = gie_hold;
            next_gie_hold  = 1'b0;
        end
        if (gie_cleared)
            next_gie_hold = 1'b1;
        next_sleeping = sleeping;
        next_wake     = 1'b0;
        if (SLEEP_ENTER)
            next_sleeping = 1'b1;
        if (wake_now)
        begin
            next_sleeping = 1'b0;
            next_wake     = 1'b1;
        end
        next_state        = state;
        next_entry_pulse  = 1'b0;
        next_vector_pulse = 1'b0;
        next_stack_data   = stack_data;
        next_vector_addr  = vector_addr;
        unique case (state)
            IRL_ST_RUN:
            begin
                if (take)
                begin
                    next_state       = IRL_ST_ENTRY;
                    next_entry_pulse = 1'b1;
                    next_stack_data  = RETURN_PC;
                end
            end
            IRL_ST_ENTRY:
            begin
                if (is_q1)
                begin
                    next_state        = IRL_ST_RUN;
                    next_vector_pulse = 1'b1;
                    next_vector_addr  = `IRL_VECTOR;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            timer_prev   <= `IRL_ZERO8;
            port_latch   <= '0;
            port_primed  <= 1'b0;
            ext_pending  <= 1'b0;
            gie_hold     <= 1'b0;
            nop_cycle    <= 1'b0;
            sleeping     <= 1'b0;
            WAKE         <= 1'b0;
            state        <= IRL_ST_RUN;
            entry_pulse  <= 1'b0;
            vector_pulse <= 1'b0;
            stack_data   <= `IRL_PC_ZERO;
            vector_addr  <= `IRL_PC_ZERO;
        end
        else if (CE)
        begin
            timer_prev   <= next_timer_prev;
            port_latch   <= next_port_latch;
            port_primed  <= next_port_primed;
            ext_pending  <= next_ext_pending;
            gie_hold     <= next_gie_hold;
            nop_cycle    <= next_nop_cycle;
            sleeping     <= next_sleeping;
            WAKE         <= next_wake;
            state        <= next_state;
            entry_pulse  <= next_entry_pulse;
            vector_pulse <= next_vector_pulse;
            stack_data   <= next_stack_data;
            vector_addr  <= next_vector_addr;
        end
    end

    always_comb
    begin
        CORE_REQ    = pending;
        IRQ_ENTRY   = entry_pulse;
        STACK_DATA  = stack_data;
        VECTOR_LOAD = vector_pulse;
        VECTOR_ADDR = vector_addr;
        FORCE_NOP   = nop_cycle;
        SLEEPING    = sleeping;
        Q1_PHASE    = is_q1;
        IRQ         = |(evt_stat & evt_mask);
    end
endmodule

// ### pkg/irl_defs.svh
// Offsets, field positions, reset values and fixed codes of the interrupt request logic.
`ifndef IRL_DEFS_SVH
`define IRL_DEFS_SVH

`define IRL_REG_CTRL      8'h0b
`define IRL_REG_PFLAG     8'h0c
`define IRL_REG_OPTION    8'h81
`define IRL_REG_PEN       8'h8c
`define IRL_REG_EVT_STAT  8'he0
`define IRL_REG_EVT_MASK  8'he1

`define IRL_CTRL_GIE      7
`define IRL_CTRL_PEIE     6
`define IRL_CTRL_TOV_EN   5
`define IRL_CTRL_EXT_EN   4
`define IRL_CTRL_PCH_EN   3
`define IRL_CTRL_TOV_FLAG 2
`define IRL_CTRL_EXT_FLAG 1
`define IRL_CTRL_PCH_FLAG 0
`define IRL_OPT_EDGE_SEL  6
`define IRL_PER_CMP_BIT   6
`define IRL_PER_MASK      8'h40

`define IRL_EVT_TAKEN     0
`define IRL_EVT_WAKE      1
`define IRL_EVT_NOP       2
`define IRL_EVT_MASK_ALL  8'h07

`define IRL_CTRL_RST      8'h00
`define IRL_OPTION_RST    8'hff
`define IRL_ZERO8         8'h00
`define IRL_TIMER_MAX     8'hff
`define IRL_TIMER_ZERO    8'h00
`define IRL_VECTOR        13'h0004
`define IRL_PC_ZERO       13'h0000

`endif

// ### pkg/irl_pkg.sv
// Types shared by the interrupt request logic modules.
package irl_pkg;
    typedef enum logic [1:0] {IRL_Q1, IRL_Q2, IRL_Q3, IRL_Q4} irl_phase_t;
    typedef enum logic [1:0] {IRL_ST_RUN, IRL_ST_ENTRY} irl_state_t;
endpackage

// ### logic/irl_phase_gen.sv
// Four-phase instruction cycle sequencer, one phase per enabled clock.
module irl_phase_gen
    import irl_pkg::*;
(
    input  wire logic       clk,    // System clock.
    input  wire logic       rst,    // Synchronous reset, active high.
    input  wire logic       ce,     // Clock enable.
    output irl_phase_t      phase   // Current phase.
);
    irl_phase_t next_phase;

    always_comb
    begin
        unique case (phase)
            IRL_Q1:  next_phase = IRL_Q2;
            IRL_Q2:  next_phase = IRL_Q3;
            IRL_Q3:  next_phase = IRL_Q4;
            IRL_Q4:  next_phase = IRL_Q1;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            phase <= IRL_Q1;
        else if (ce)
            phase <= next_phase;
    end
endmodule

// ### logic/irl_edge_det.sv
// Per-bit rising and falling edge detector, quiet until it has seen one sample after reset.
module irl_edge_det #(
    parameter int W = 1
) (
    input  wire logic         clk,   // System clock.
    input  wire logic         rst,   // Synchronous reset, active high.
    input  wire logic         ce,    // Clock enable.
    input  wire logic [W-1:0] din,   // Sampled levels.
    output logic      [W-1:0] rise,  // Rising edge this cycle.
    output logic      [W-1:0] fall   // Falling edge this cycle.
);
    logic [W-1:0] prev;
    logic         primed;
    logic [W-1:0] next_prev;
    logic         next_primed;

    always_comb
    begin
        next_prev   = din;
        next_primed = 1'b1;
        rise        = primed ? (din & ~prev) : '0;
        fall        = primed ? (~din & prev) : '0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev   <= '0;
            primed <= 1'b0;
        end
        else if (ce)
        begin
            prev   <= next_prev;
            primed <= next_primed;
        end
    end
endmodule

// ### verif/irl_asserts.sv
// Concurrent checks on the ports of the interrupt request logic.
module irl_asserts (
    input wire logic        MCLK,        // Clock.
    input wire logic        SYS_RST,     // Reset.
    input wire logic [12:0] RETURN_PC,   // Core address.
    input wire logic        CORE_REQ,    // Request.
    input wire logic        IRQ_ENTRY,   // Entry pulse.
    input wire logic [12:0] STACK_DATA,  // Pushed address.
    input wire logic        VECTOR_LOAD, // Vector pulse.
    input wire logic [12:0] VECTOR_ADDR, // Vector.
    input wire logic        FORCE_NOP,   // No-op slot.
    input wire logic        SLEEPING,    // Asleep.
    input wire logic        WAKE,        // Wake pulse.
    input wire logic        SLEEP_ENTER, // Sleep request.
    input wire logic        Q1_PHASE     // Phase Q1.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    sequence s_vector;
        ##4 (VECTOR_LOAD && VECTOR_ADDR == 13'h0004) ##1 !VECTOR_LOAD;
    endsequence
    sequence s_cycle;
        !Q1_PHASE [*3] ##1 Q1_PHASE;
    endsequence
    a_entry_vector: assert property (IRQ_ENTRY |-> s_vector)
        else $error("vector load missing after entry");
    a_entry_pulse: assert property (IRQ_ENTRY |=> !IRQ_ENTRY)
        else $error("entry pulse too long");
    a_entry_at_q1: assert property (IRQ_ENTRY |-> $past(Q1_PHASE) && $past(CORE_REQ))
        else $error("entry without request at Q1");
    a_stack_push: assert property (IRQ_ENTRY |-> STACK_DATA == $past(RETURN_PC))
        else $error("wrong address pushed");
    a_stack_hold: assert property (!IRQ_ENTRY && !$past(SYS_RST) |-> $stable(STACK_DATA))
        else $error("pushed address changed");
    a_nop_length: assert property ($rose(FORCE_NOP) |-> FORCE_NOP [*4] ##1 !FORCE_NOP)
        else $error("no-op slot not one instruction");
    a_nop_blocks: assert property (FORCE_NOP |-> !IRQ_ENTRY)
        else $error("entry during no-op slot");
    a_wake_cause: assert property (WAKE |-> $past(SLEEPING) && $past(CORE_REQ) && !SLEEPING)
        else $error("wake without enabled request");
    a_sleep_cause: assert property ($rose(SLEEPING) |-> $past(SLEEP_ENTER))
        else $error("sleep without request");
    a_phase_cycle: assert property (Q1_PHASE |=> s_cycle)
        else $error("phase sequence broken");
endmodule

bind irl_top irl_asserts u_asserts (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .RETURN_PC(RETURN_PC), .CORE_REQ(CORE_REQ),
    .IRQ_ENTRY(IRQ_ENTRY), .STACK_DATA(STACK_DATA), .VECTOR_LOAD(VECTOR_LOAD),
    .VECTOR_ADDR(VECTOR_ADDR), .FORCE_NOP(FORCE_NOP), .SLEEPING(SLEEPING), .WAKE(WAKE),
    .SLEEP_ENTER(SLEEP_ENTER), .Q1_PHASE(Q1_PHASE)
);

// ### verif/irl_core_model.sv
// Behavioural model of the core that sits beside the interrupt request logic.
module irl_core_model (
    input  wire logic        clk,         // Clock.
    input  wire logic        rst,         // Reset.
    input  wire logic        irq_entry,   // Entry pulse.
    input  wire logic [12:0] stack_data,  // Address to push.
    input  wire logic        vector_load, // Vector pulse.
    input  wire logic [12:0] vector_addr, // Vector.
    input  wire logic        do_ret,      // Bench asks for a return.
    input  wire logic        do_sleep,    // Bench asks for sleep.
    output logic      [12:0] return_pc,   // Program counter.
    output logic             ret_pulse,   // Return instruction.
    output logic             sleep_pulse  // Sleep instruction.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] stack_top;
    // Only the program counter is kept; other state is left to software.
    always_ff @(posedge clk)
    begin
        ret_pulse <= do_ret;
        sleep_pulse <= do_sleep;
        if (irq_entry)
            stack_top <= stack_data;
        if (rst)
            return_pc <= 13'h0000;
        else if (vector_load)
            return_pc <= vector_addr;
        else if (do_ret)
            return_pc <= stack_top;
        else
            return_pc <= return_pc + 13'h0001;
    end
endmodule

// ### verif/interrupt_request_logic_tb.sv
// Self-checking bench for the interrupt request logic.
`include "irl_defs.svh"
module interrupt_request_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk;
    logic        sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, pin = 1'b1, cmp = 1'b0, prd = 1'b1;
    logic        do_ret = 1'b0, do_sleep = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, tcount = 8'h00, rdata, d;
    logic [3:0]  gpio = 4'h0;
    logic [12:0] rpc, stack_data, vaddr;
    logic        rfi, slp, core_req, irq_entry, vload, force_nop, sleeping, wake, q1, irq;
    int          err_count = 0, samples_checked = 0, n;
    wire  [3:0]  evs = {wake, force_nop, vload, irq_entry};

    irl_top DUT (
        .MCLK(mclk), .SYS_RST(sys_rst), .CE(1'b1), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .EXT_IRQ_PIN(pin), .TIMER_COUNT(tcount), .GPIO_BANK_TWO_HI(gpio),
        .PORT_READ(prd), .CMP_OUT(cmp), .RETURN_FROM_IRQ(rfi), .SLEEP_ENTER(slp), .RETURN_PC(rpc),
        .CORE_REQ(core_req), .IRQ_ENTRY(irq_entry), .STACK_DATA(stack_data), .VECTOR_LOAD(vload),
        .VECTOR_ADDR(vaddr), .FORCE_NOP(force_nop), .SLEEPING(sleeping), .WAKE(wake),
        .Q1_PHASE(q1), .IRQ(irq)
    );
    irl_core_model u_core (
        .clk(mclk), .rst(sys_rst), .irq_entry(irq_entry), .stack_data(stack_data),
        .vector_load(vload), .vector_addr(vaddr), .do_ret(do_ret), .do_sleep(do_sleep),
        .return_pc(rpc), .ret_pulse(rfi), .sleep_pulse(slp)
    );

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic ovf(input logic [7:0] p, input logic [7:0] c);
        return p == 8'hff && c == 8'h00;
    endfunction

    task automatic stop_test();
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk({5'h00, rdata}, {5'h00, e});
    endtask

    task automatic wait_ev(input int sel, input int lim, output int k);
        k = 0;
        do
        begin
            @(posedge mclk);
            #1;
            k++;
            if (k > lim)
            begin
                err_count++;
                stop_test();
            end
        end
        while (evs[sel] !== 1'b1);
    endtask

    // Returns on the edge that starts Q3, so a pin change never meets the Q2 port read.
    task automatic sync_q3();
        int k;
        k = 0;
        do
        begin
            @(posedge mclk);
            #1;
            k++;
        end
        while (q1 !== 1'b1 && k < 8);
        if (q1 !== 1'b1)
        begin
            err_count++;
            stop_test();
        end
        repeat (2) @(posedge mclk);
    endtask

    task automatic pin_rise();
        sync_q3();
        pin <= 1'b0;
        sync_q3();
        pin <= 1'b1;
    endtask

    task automatic core_sleep();
        @(posedge mclk);
        do_sleep <= 1'b1;
        @(posedge mclk);
        do_sleep <= 1'b0;
    endtask

    logic [7:0]  ra [7] = '{`IRL_REG_CTRL, `IRL_REG_PFLAG, `IRL_REG_OPTION, `IRL_REG_PEN,
                           `IRL_REG_EVT_STAT, `IRL_REG_EVT_MASK, 8'h55};
    logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  prev, v;
    logic [31:0] r;
    logic        exp_ovf;

    initial
    begin
        void'($urandom(32'h48ed9f86));
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        foreach (ra[i])
            chk_reg(ra[i], rv[i]);
        for (int e = 0; e < 2; e++)
        begin
            wr_reg(`IRL_REG_OPTION, e ? 8'hff : 8'hbf);
            sync_q3();
            pin <= ~e[0];
            wr_reg(`IRL_REG_CTRL, 8'h00);
            chk_reg(`IRL_REG_CTRL, 8'h00);
            sync_q3();
            pin <= e[0];
            // The flag lands at the end of Q4, so the read must start in Q1.
            @(posedge mclk);
            chk_reg(`IRL_REG_CTRL, 8'h02);
        end
        wr_reg(`IRL_REG_CTRL, 8'h00);
        prev = tcount;
        exp_ovf = 1'b0;
        repeat (200)
        begin
            @(posedge mclk);
            r = $urandom;
            v = (r[1:0] == 2'b00) ? 8'hff : (r[2] ? 8'h00 : r[15:8]);
            exp_ovf = exp_ovf | ovf(prev, v);
            tcount <= v;
            prev = v;
        end
        @(posedge mclk);
        chk_reg(`IRL_REG_CTRL, {5'h00, exp_ovf, 2'b00});
        wr_reg(`IRL_REG_CTRL, 8'h00);
        sync_q3();
        gpio <= 4'($urandom_range(15, 1));
        chk_reg(`IRL_REG_CTRL, 8'h01);
        wr_reg(`IRL_REG_CTRL, 8'h00);
        chk_reg(`IRL_REG_CTRL, 8'h00);
        // A change in Q2 is lost beside a port read and seen without one.
        for (int p = 0; p < 2; p++)
        begin
            prd <= !p;
            sync_q3();
            repeat (3) @(posedge mclk);
            gpio <= ~gpio;
            repeat (8) @(posedge mclk);
            chk_reg(`IRL_REG_CTRL, 8'(p));
        end
        prd <= 1'b1;
        repeat (4) @(posedge mclk);
        wr_reg(`IRL_REG_CTRL, 8'h00);
        cmp <= 1'b1;
        chk_reg(`IRL_REG_PFLAG, 8'h40);
        wr_reg(`IRL_REG_CTRL, 8'h80);
        wr_reg(`IRL_REG_CTRL, 8'h10);
        wait_ev(2, 12, n);
        pin_rise();
        repeat (12) @(posedge mclk);
        chk({12'h000, core_req}, 13'h0001);
        chk_reg(`IRL_REG_EVT_STAT, 8'h04);
        // Bit 1 is written as one so the pending flag survives the write.
        wr_reg(`IRL_REG_CTRL, 8'h92);
        wait_ev(0, 12, n);
        wait_ev(1, 8, n);
        @(posedge mclk);
        #1;
        chk(rpc, `IRL_VECTOR);
        chk_reg(`IRL_REG_CTRL, 8'h12);
        wr_reg(`IRL_REG_CTRL, 8'h10);
        @(posedge mclk);
        do_ret <= 1'b1;
        @(posedge mclk);
        do_ret <= 1'b0;
        chk_reg(`IRL_REG_CTRL, 8'h90);
        pin_rise();
        wait_ev(1, 20, n);
        chk(13'(n <= 16), 13'h0001);
        chk_reg(`IRL_REG_CTRL, 8'h12);
        wr_reg(`IRL_REG_CTRL, 8'h80);
        pin_rise();
        repeat (12) @(posedge mclk);
        chk_reg(`IRL_REG_CTRL, 8'h82);
        chk_reg(`IRL_REG_EVT_STAT, 8'h05);
        wr_reg(`IRL_REG_EVT_MASK, 8'h01);
        #1;
        chk({12'h000, irq}, 13'h0001);
        wr_reg(`IRL_REG_EVT_STAT, 8'h07);
        #1;
        chk({12'h000, irq}, 13'h0000);
        wr_reg(`IRL_REG_CTRL, 8'h10);
        core_sleep();
        pin_rise();
        wait_ev(3, 20, n);
        repeat (12) @(posedge mclk);
        chk_reg(`IRL_REG_EVT_STAT, 8'h06);
        wr_reg(`IRL_REG_PFLAG, 8'h00);
        wr_reg(`IRL_REG_PEN, 8'h40);
        wr_reg(`IRL_REG_CTRL, 8'h40);
        core_sleep();
        sync_q3();
        cmp <= 1'b0;
        wait_ev(3, 20, n);
        chk_reg(`IRL_REG_PFLAG, 8'h40);
        stop_test();
    end
endmodule
